// ### inc/pm_table_pkg.sv
// constants for the program store and table read block
// assumes one 200 MHz clock and a cpu core that issues table reads
// How it works
// - the program store holds 8K words of 16 bits, addressed by the pc.
// - after any reset the fetch address starts at the reset entry, zero.
// - outside the last-page forms, the table address is the high pointer joined above the low pointer.
// - a table read copies the word's low byte to the operand register.
// - the same read loads the word's high byte into the table-high latch.
// - short table reads only reach destinations in data sector 0.
// - extended table reads do the same transfer for any other sector.
// - every table instruction takes exactly two instruction cycles.
// - software can read and write the table-high latch.
// - programming data moves serially on one data pin with a clock pin.
// - the debug port is a data pin that is never driven (prog_serial_data_oe_n stays high) and a tool-driven clock pin.
// - on the emulation part the debug pins still serve as program pins.
package pm_table_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 16;
  localparam int DEPTH = 8192;
  localparam int DADDR_W = 10;
  localparam int SECTOR_W = 2;
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [7:0] TBL_HIGH_RESET = 8'h00;
  localparam logic [1:0] SECTOR_ZERO = 2'h0;
  localparam int TBL_CYCLES = 2;
  localparam int SYNC_STAGES = 3;
  typedef enum logic [1:0] {
    TR_SHORT,
    TR_SHORT_LAST,
    TR_EXT,
    TR_EXT_LAST
  } tread_kind_t;
endpackage

// ### inc/pm_store_if.sv
// read port between the table engine and the program word store
// assumes one clock; data answers one cycle after the request
`timescale 1ns/100ps
interface pm_store_if;
  import pm_table_pkg::*;
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  modport master (output rd_en, output rd_addr, input rd_data,
    output wr_en, output wr_addr, output wr_data);
  modport store (input rd_en, input rd_addr, output rd_data,
    input wr_en, input wr_addr, input wr_data);
endinterface

// ### core/pm_word_store.sv
// flip-flop program store of 8K words of 16 bits
// assumes registered read: data valid the cycle after rd_en
`timescale 1ns/100ps
module pm_word_store
  import pm_table_pkg::*;
(
  input wire logic sys_clk,
  pm_store_if.store bus
);
  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [DATA_W-1:0] rd_q;

  // no reset on the array: contents persist as in flash
  always_ff @(posedge sys_clk) begin
    if (bus.wr_en) begin
      mem_q[bus.wr_addr] <= bus.wr_data;
    end
    if (bus.rd_en) begin
      rd_q <= mem_q[bus.rd_addr];
    end
  end

  assign bus.rd_data = rd_q;
endmodule

// ### core/program_memory_table_read.sv
// table read engine with program store and program/debug pin handling
// assumes the cpu raises cmd_valid for one cycle per table instruction
`timescale 1ns/100ps
module program_memory_table_read
  import pm_table_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  // fetch side
  input wire logic fetch_req,
  input wire logic [ADDR_W-1:0] fetch_addr,
  output logic [ADDR_W-1:0] fetch_pc,
  output logic [DATA_W-1:0] fetch_word,
  output logic fetch_valid,
  // table pointer and command
  input wire logic [7:0] tbl_ptr_low,
  input wire logic [7:0] tbl_ptr_high,
  input wire logic cmd_valid,
  input wire tread_kind_t cmd_kind,
  input wire logic [DADDR_W-1:0] cmd_dest,
  output logic busy,
  output logic done,
  output logic dest_we,
  output logic [DADDR_W-1:0] dest_addr,
  output logic [7:0] dest_data,
  output logic cmd_reject,
  // table-high latch access
  input wire logic tbl_high_we,
  input wire logic [7:0] tbl_high_wdata,
  output logic [7:0] table_high_byte_latch,
  // in-circuit programming loader
  input wire logic prog_serial_clock_pin,
  input wire logic prog_serial_data_in,
  output logic prog_serial_data_out,
  output logic prog_serial_data_oe_n,
  input wire logic prog_mode,
  input wire logic emulation_mode,
  output logic pin_func_blocked
);
  ////////////////////////////////////////////////////////////////////
  pm_store_if st ();
  pm_word_store u_store (
    .sys_clk(sys_clk),
    .bus(st.store)
  );

  typedef enum logic [1:0] {IDLE, FETCH, FINISH} tstate_t;
  tstate_t state_q, state_d;
  logic [DADDR_W-1:0] dest_q;
  logic fetch_pend_q;

  function automatic logic sector_ok(input tread_kind_t k,
      input logic [DADDR_W-1:0] d);
    logic is_short;
    is_short = (k == TR_SHORT) || (k == TR_SHORT_LAST);
    return is_short ? (d[DADDR_W-1 -: SECTOR_W] == SECTOR_ZERO) : 1'b1;
  endfunction

  // last-page forms keep only the low pointer, page forced to the top
  wire [ADDR_W-1:0] tbl_addr_full = {tbl_ptr_high[4:0], tbl_ptr_low};
  wire last_page = (cmd_kind == TR_SHORT_LAST) || (cmd_kind == TR_EXT_LAST);
  wire [ADDR_W-1:0] tbl_addr = last_page ?
    {5'h1F, tbl_ptr_low} : tbl_addr_full;
  wire cmd_ok = sector_ok(cmd_kind, cmd_dest);
  wire eng_idle = (state_q == IDLE);
  wire eng_fetch = (state_q == FETCH);
  wire start = eng_idle && cmd_valid && cmd_ok;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      IDLE: if (start) state_d = FETCH;
      FETCH: state_d = FINISH;
      FINISH: state_d = IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // programming loader: three-stage sync on pin inputs
  wire [1:0] pin_stable;
  logic ck_prev_q;
  logic [ADDR_W+DATA_W-1:0] shift_q;
  logic [5:0] bit_cnt_q;
  // bit 0 is the tool-driven clock, bit 1 the data line
  wire [1:0] pin_raw = {prog_serial_data_in, prog_serial_clock_pin};
  wire ck_stable = pin_stable[0];
  wire da_stable = pin_stable[1];
  wire prog_active = prog_mode;
  wire ck_rise = ck_stable && !ck_prev_q;
  wire frame_done = prog_active && ck_rise &&
    (bit_cnt_q == 6'(ADDR_W + DATA_W - 1));

  for (genvar i = 0; i < 2; i++) begin : g_pin_sync
    logic [SYNC_STAGES-1:0] sync_q;
    logic stable_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        sync_q <= '0;
        stable_q <= 1'b0;
      end else begin
        sync_q <= {sync_q[SYNC_STAGES-2:0], pin_raw[i]};
        // a one-cycle glitch never reaches the shifter
        if (sync_q[1] == sync_q[2]) stable_q <= sync_q[2];
      end
    end
    assign pin_stable[i] = stable_q;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ck_prev_q <= 1'b0;
    end else begin
      ck_prev_q <= ck_stable;
    end
  end

  // serial frame: address first then data, msb first
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_q <= '0;
      bit_cnt_q <= '0;
      prog_serial_data_out <= 1'b0;
      prog_serial_data_oe_n <= 1'b1;
    end else if (!prog_active) begin
      bit_cnt_q <= '0;
      prog_serial_data_oe_n <= 1'b1;
    end else if (ck_rise) begin
      shift_q <= {shift_q[ADDR_W+DATA_W-2:0], da_stable};
      bit_cnt_q <= frame_done ? 6'h00 : bit_cnt_q + 6'h01;
      // shifted-out bit goes to prog_serial_data_out, but prog_serial_data_oe_n stays high so the pin is never driven
      prog_serial_data_out <= shift_q[ADDR_W+DATA_W-1];
      prog_serial_data_oe_n <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // single read port shared: table read beats fetch, fetch dropped that cycle
  wire tbl_rd = start;
  wire fetch_rd = fetch_req && !tbl_rd;
  assign st.rd_en = tbl_rd || fetch_rd;
  assign st.rd_addr = tbl_rd ? tbl_addr : fetch_addr;
  assign st.wr_en = frame_done;
  assign st.wr_addr = shift_q[ADDR_W+DATA_W-2 -: ADDR_W];
  assign st.wr_data = {shift_q[DATA_W-2:0], da_stable};

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= IDLE;
      busy <= 1'b0;
    end else begin
      state_q <= state_d;
      busy <= (state_d != IDLE);
    end
  end

  // a refused read leaves the engine idle and the latch untouched
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_reject <= 1'b0;
    end else begin
      cmd_reject <= eng_idle && cmd_valid && !cmd_ok;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dest_q <= '0;
    end else if (start) begin
      dest_q <= cmd_dest;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fetch_pend_q <= 1'b0;
      fetch_valid <= 1'b0;
    end else begin
      fetch_pend_q <= fetch_rd;
      fetch_valid <= fetch_pend_q;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fetch_pc <= RESET_VECTOR;
      fetch_word <= '0;
    end else begin
      if (fetch_rd) fetch_pc <= fetch_addr;
      if (fetch_pend_q) fetch_word <= st.rd_data;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dest_we <= 1'b0;
      done <= 1'b0;
    end else begin
      dest_we <= eng_fetch;
      done <= eng_fetch;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dest_addr <= '0;
      dest_data <= '0;
    end else if (eng_fetch) begin
      dest_addr <= dest_q;
      dest_data <= st.rd_data[7:0];
    end
  end

  // table read wins a same-cycle software write: its word is newer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      table_high_byte_latch <= TBL_HIGH_RESET;
    end else if (eng_fetch) begin
      table_high_byte_latch <= st.rd_data[15:8];
    end else if (tbl_high_we) begin
      table_high_byte_latch <= tbl_high_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_func_blocked <= 1'b0;
    end else begin
      pin_func_blocked <= emulation_mode || prog_mode;
    end
  end
endmodule

// ### tb/cpu_data_model.sv
// data register file of the cpu core, far side of the table read path
// assumes destination writes arrive as one-cycle dest_we pulses
`timescale 1ns/100ps
module cpu_data_model
  import pm_table_pkg::*;
(
  input wire logic sys_clk,
  input wire logic dest_we,
  input wire logic [DADDR_W-1:0] dest_addr,
  input wire logic [7:0] dest_data
);
  logic [7:0] mem_q [0:(1<<DADDR_W)-1];
  always_ff @(posedge sys_clk) begin
    if (dest_we) mem_q[dest_addr] <= dest_data;
  end
endmodule

// ### tb/pm_table_assertions.sv
// timing checks on the table read block ports
// assumes binding to every instance of the top module
`timescale 1ns/100ps
module pm_table_assertions
  import pm_table_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic fetch_req,
  input wire logic fetch_valid,
  input wire logic cmd_valid,
  input wire tread_kind_t cmd_kind,
  input wire logic [DADDR_W-1:0] cmd_dest,
  input wire logic busy,
  input wire logic done,
  input wire logic dest_we,
  input wire logic cmd_reject,
  input wire logic tbl_high_we,
  input wire logic [7:0] tbl_high_wdata,
  input wire logic [7:0] table_high_byte_latch,
  input wire logic prog_serial_data_oe_n,
  input wire logic emulation_mode,
  input wire logic pin_func_blocked
);
  wire short_k = cmd_kind inside {TR_SHORT, TR_SHORT_LAST};
  wire bad = short_k && cmd_dest[9:8] != SECTOR_ZERO;
  wire take = cmd_valid && !busy && !bad;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_take; take; endsequence
  sequence s_end; done && dest_we; endsequence
  property p_two; s_take |-> ##1 busy ##1 s_end; endproperty
  a_two: assert property (p_two) else $error("read not done in two");
  property p_cause; done |-> $past(take, 2); endproperty
  a_cause: assert property (p_cause) else $error("done without read");
  property p_rej; cmd_valid && !busy && bad |=> cmd_reject ##1 !dest_we;
  endproperty
  a_rej: assert property (p_rej) else $error("bad sector not refused");
  property p_hold;
    $changed(table_high_byte_latch) |-> done || $past(tbl_high_we);
  endproperty
  a_hold: assert property (p_hold) else $error("latch changed alone");
  property p_wr;
    tbl_high_we && !busy |=> table_high_byte_latch == $past(tbl_high_wdata);
  endproperty
  a_wr: assert property (p_wr) else $error("latch write lost");
  property p_fetch; fetch_req && !take |-> ##2 fetch_valid; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch not answered");
  property p_oe; prog_serial_data_oe_n; endproperty
  a_oe: assert property (p_oe) else $error("serial pin driven");
  property p_emu; emulation_mode [*2] |-> pin_func_blocked; endproperty
  a_emu: assert property (p_emu) else $error("shared pin not blocked");
endmodule
bind program_memory_table_read pm_table_assertions i_pm_table_assertions (.*);

// ### tb/program_memory_table_read_test.sv
// self-checking bench for the table read block
// assumes the loader writes a word at the end of each 29-bit frame
`timescale 1ns/100ps
`define CHK(n, e, a) begin comparisons++; \
  if ((a) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module program_memory_table_read_test;
  import pm_table_pkg::*;
  logic sys_clk = '0, reset_n = '0, fetch_req = '0, cmd_valid = '0;
  logic tbl_high_we = '0, prog_mode = '0, emulation_mode = '0;
  logic prog_serial_clock_pin = '0, prog_serial_data_in = '0;
  logic [ADDR_W-1:0] fetch_addr = '0, fetch_pc;
  logic [DATA_W-1:0] fetch_word;
  logic [7:0] tbl_ptr_low = '0, tbl_ptr_high = '0, tbl_high_wdata = '0;
  logic [7:0] dest_data, table_high_byte_latch;
  logic [DADDR_W-1:0] cmd_dest = '0, dest_addr;
  tread_kind_t cmd_kind = TR_SHORT;
  logic fetch_valid, busy, done, dest_we, cmd_reject, pin_func_blocked;
  logic prog_serial_data_out, prog_serial_data_oe_n;
  int failures = 0, comparisons = 0;
  program_memory_table_read i_program_memory_table_read (.*);
  cpu_data_model i_cpu_data_model (.*);
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic tick(int n = 1);
    repeat (n) @(negedge sys_clk);
  endtask
  // slow serial clock so the 3-stage sync sees every level
  task automatic load(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    logic [28:0] f;
    f = {a, d};
    prog_mode = 1'b1;
    for (int i = 28; i >= 0; i--) begin
      prog_serial_data_in = f[i];
      tick(4);
      prog_serial_clock_pin = 1'b1;
      tick(4);
      prog_serial_clock_pin = 1'b0;
    end
    prog_serial_data_in = ~f[0];
    tick(6);
    prog_mode = 1'b0;
  endtask
  task automatic tread(tread_kind_t k, logic [7:0] pl, ph,
      logic [9:0] d, logic [15:0] w);
    tbl_ptr_low = pl;
    tbl_ptr_high = ph;
    cmd_kind = k;
    cmd_dest = d;
    tbl_high_we = 1'b0;
    cmd_valid = 1'b1;
    tick();
    cmd_valid = 1'b0;
    `CHK("busy", 1'b1, busy)
    `CHK("done_early", 1'b0, done)
    tick();
    `CHK("busy_two", 1'b1, busy)
    `CHK("done", 1'b1, done)
    `CHK("dest_we", 1'b1, dest_we)
    `CHK("dest_addr", d, dest_addr)
    `CHK("dest_data", w[7:0], dest_data)
    `CHK("latch", w[15:8], table_high_byte_latch)
    tick();
    `CHK("busy_end", 1'b0, busy)
    `CHK("done_end", 1'b0, done)
    `CHK("cpu_reg", w[7:0], i_cpu_data_model.mem_q[d])
  endtask
  task automatic t_reset();
    `CHK("fetch_pc", RESET_VECTOR, fetch_pc)
    `CHK("latch_rst", TBL_HIGH_RESET, table_high_byte_latch)
    load(13'h0000, 16'h1234);
    `CHK("data_out", 1'b0, prog_serial_data_out)
    fetch_addr = RESET_VECTOR;
    fetch_req = 1'b1;
    tick();
    fetch_req = 1'b0;
    tick();
    `CHK("fetch_valid", 1'b1, fetch_valid)
    `CHK("fetch_word", 16'h1234, fetch_word)
    `CHK("fetch_pc_req", RESET_VECTOR, fetch_pc)
    tick();
    `CHK("fetch_valid_end", 1'b0, fetch_valid)
    $display("t_reset done");
  endtask
  task automatic t_tables();
    load(13'h1F06, 16'hA51A);
    load(13'h1F05, 16'h0F3C);
    tread(TR_SHORT, 8'h06, 8'h1F, 10'h010, 16'hA51A);
    tread(TR_SHORT_LAST, 8'h05, 8'h00, 10'h011, 16'h0F3C);
    tread(TR_EXT, 8'h06, 8'h1F, 10'h2A0, 16'hA51A);
    tread(TR_EXT_LAST, 8'h05, 8'h03, 10'h3FF, 16'h0F3C);
    $display("t_tables done");
  endtask
  task automatic t_reject();
    cmd_kind = TR_SHORT;
    cmd_dest = 10'h120;
    cmd_valid = 1'b1;
    tick();
    cmd_valid = 1'b0;
    `CHK("cmd_reject", 1'b1, cmd_reject)
    tick(2);
    `CHK("dest_we", 1'b0, dest_we)
    `CHK("latch_kept", 8'h0F, table_high_byte_latch)
    $display("t_reject done");
  endtask
  task automatic t_latch();
    tbl_high_wdata = 8'h5E;
    tbl_high_we = 1'b1;
    tick();
    tbl_high_we = 1'b0;
    `CHK("latch_wr", 8'h5E, table_high_byte_latch)
    tick(5);
    `CHK("latch_hold", 8'h5E, table_high_byte_latch)
    emulation_mode = 1'b1;
    tick(3);
    `CHK("pin_blocked", 1'b1, pin_func_blocked)
    `CHK("data_oe_n", 1'b1, prog_serial_data_oe_n)
    emulation_mode = 1'b0;
    $display("t_latch done");
  endtask
  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    tick(5);
    reset_n = 1'b1;
    t_reset();
    t_tables();
    t_reject();
    t_latch();
    conclude();
  end
  // run needs about 750 cycles; this leaves a wide margin
  initial begin
    #100000;
    failures++;
    conclude();
  end
endmodule
